// ===== shared/psw_map.svh
/*
 * Constants for the processor sleep and wakeup controller.
 * Assumes inclusion by bare name from any design file.
 */
`ifndef PSW_MAP_SVH
`define PSW_MAP_SVH

// Reset value of the one-bit event register
`define PSW_EVENT_RST     1'b0
// State codes
`define PSW_ST_RUN        2'h0
`define PSW_ST_SLEEP_INT  2'h1
`define PSW_ST_SLEEP_EVT  2'h2

`endif

// ===== shared/psw_pkg.sv
/*
 * Types for the processor sleep and wakeup controller.
 * Assumes psw_map.svh is on the include path.
 */
`default_nettype none

`include "psw_map.svh"

package psw_pkg;

    // Controller state
    typedef enum logic [1:0] {
        PSW_RUN       = `PSW_ST_RUN,
        PSW_SLEEP_INT = `PSW_ST_SLEEP_INT,
        PSW_SLEEP_EVT = `PSW_ST_SLEEP_EVT
    } psw_state_t;

    // Sleep requests from the core
    typedef struct packed {
        logic wait_interrupt_instr;  // Wait-for-interrupt executed
        logic wait_event_instr;      // Wait-for-event executed
        logic handler_done;          // Exception handler returning to thread
    } psw_req_t;

    // Configuration bits of the system control register
    typedef struct packed {
        logic deep_sleep_select;     // 1: deep sleep level
        logic sleep_after_handler;   // Sleep on handler completion
        logic wake_on_pending;       // New pending interrupt raises event
    } psw_cfg_t;

    // Wake sources
    typedef struct packed {
        logic exc_entry_ok;          // Exception can cause entry
        logic irq_wake_masked;       // Enabled higher-priority irq held by mask
        logic new_pending;           // Interrupt newly pending, any priority
        logic ext_event;             // External event pin, asynchronous
        logic send_event;            // Send-event from other processor, async
        logic debug_wake;            // Spurious wake such as debug
    } psw_wake_t;

    // Clock and power controls
    typedef struct packed {
        logic cpu_clk_en;            // Processor clock enable
        logic sys_clk_en;            // System clock enable
        logic pll_on;                // PLL powered
        logic flash_on;              // Flash powered
    } psw_pwr_t;

endpackage

`default_nettype wire

// ===== rtl/psw_ctrl.sv
/*
 * Sleep entry and wakeup control for the processor core.
 * Assumes the core presents one-cycle request pulses on clk, and that
 * external event and send-event lines are asynchronous to clk.
 */
`timescale 1ns/1ns
`default_nettype none

`include "psw_map.svh"

////////////////////////////////////////////////////////////////////////////////
module psw_ctrl (
    input  wire logic              clk,          // 50 MHz clock
    input  wire logic              rst_b,        // Async reset, active low
    input  wire psw_pkg::psw_req_t  req,          // Sleep requests
    input  wire psw_pkg::psw_cfg_t  cfg,          // Control register bits
    input  wire logic              priority_mask_bit, // Priority mask
    input  wire logic              fault_mask_bit,    // Fault mask
    input  wire psw_pkg::psw_wake_t wake,         // Wake sources
    output var  psw_pkg::psw_pwr_t  pwr,          // Clock and power controls
    output logic                   sleeping,     // Processor asleep
    output logic                   wake_pulse,   // One-cycle wake pulse
    output logic                   defer_handler,// Handler held by mask
    output logic                   event_flag    // Event register value
);
    import psw_pkg::*;

    psw_state_t state_r;
    psw_state_t state_nxt;
    logic       event_r;
    logic       deep_r;
    logic       defer_r;
    logic [1:0] ext_sync_r;
    logic [1:0] sev_sync_r;
    logic       ext_d_r;
    logic       sev_d_r;
    logic       ext_rise;
    logic       sev_rise;
    logic       evt_in;
    logic       wake_int;
    logic       wake_evt;
    logic       go_sleep_int;
    logic       go_sleep_evt;

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers on the asynchronous event lines
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_sync_r <= 2'h0;
            sev_sync_r <= 2'h0;
            ext_d_r    <= 1'b0;
            sev_d_r    <= 1'b0;
        end else begin
            ext_sync_r <= {ext_sync_r[0], wake.ext_event};
            sev_sync_r <= {sev_sync_r[0], wake.send_event};
            ext_d_r    <= ext_sync_r[1];
            sev_d_r    <= sev_sync_r[1];
        end
    end

    // Edges only, so a held line raises one event, not one per cycle
    assign ext_rise = ext_sync_r[1] & ~ext_d_r;
    assign sev_rise = sev_sync_r[1] & ~sev_d_r;

    assign evt_in = ext_rise | sev_rise | (cfg.wake_on_pending & wake.new_pending);

    assign wake_int = wake.exc_entry_ok | wake.debug_wake
                    | (priority_mask_bit & ~fault_mask_bit & wake.irq_wake_masked);
    assign wake_evt = wake.exc_entry_ok | wake.debug_wake | evt_in;

    assign go_sleep_int = req.wait_interrupt_instr
                        | (req.handler_done & cfg.sleep_after_handler);
    assign go_sleep_evt = req.wait_event_instr & ~event_r & ~evt_in;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state decode
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PSW_RUN: begin
                if (go_sleep_int) begin
                    state_nxt = PSW_SLEEP_INT;
                end else if (go_sleep_evt) begin
                    state_nxt = PSW_SLEEP_EVT;
                end
            end
            PSW_SLEEP_INT: begin
                if (wake_int) begin
                    state_nxt = PSW_RUN;
                end
            end
            PSW_SLEEP_EVT: begin
                if (wake_evt) begin
                    state_nxt = PSW_RUN;
                end
            end
            default: state_nxt = PSW_RUN;
        endcase
    end

    // State register; requests from the run state may re-enter at any time
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= PSW_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // level latched at entry so a later bit change cannot tear the mode
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            deep_r <= 1'b0;
        end else if (state_r == PSW_RUN && (go_sleep_int || go_sleep_evt)) begin
            deep_r <= cfg.deep_sleep_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event register: set wins over the clear from wait-for-event
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            event_r <= `PSW_EVENT_RST;
        end else if (evt_in && state_r != PSW_SLEEP_EVT) begin
            event_r <= 1'b1;
        end else if (req.wait_event_instr && state_r == PSW_RUN) begin
            event_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // handler deferred until the priority mask clears
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            defer_r <= 1'b0;
        end else if (!priority_mask_bit) begin
            defer_r <= 1'b0;
        end else if (state_r == PSW_SLEEP_INT && wake_int && !wake.exc_entry_ok
                     && wake.irq_wake_masked) begin
            defer_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs from registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_pulse <= 1'b0;
        end else begin
            wake_pulse <= (state_r != PSW_RUN) && (state_nxt == PSW_RUN);
        end
    end

    assign sleeping      = (state_r != PSW_RUN);
    assign defer_handler = defer_r;
    assign event_flag    = event_r;

    // light sleep stops only the processor clock
    // deep sleep also stops system clock, PLL and flash
    always_comb begin
        pwr.cpu_clk_en = ~sleeping;
        pwr.sys_clk_en = ~(sleeping & deep_r);
        pwr.pll_on     = ~(sleeping & deep_r);
        pwr.flash_on   = ~(sleeping & deep_r);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    wfi_sleeps_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == PSW_RUN && req.wait_interrupt_instr) |=> state_r == PSW_SLEEP_INT)
        else $error("wait for interrupt did not sleep");

    wfe_sleep_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == PSW_RUN && !go_sleep_int && req.wait_event_instr && !event_r
         && !evt_in) |=> state_r == PSW_SLEEP_EVT)
        else $error("wait for event with clear flag did not sleep");

    wfe_skip_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == PSW_RUN && !go_sleep_int && req.wait_event_instr && event_r
         && !evt_in) |=> (state_r == PSW_RUN && !event_r))
        else $error("wait for event with set flag misbehaved");

    exit_sleep_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == PSW_RUN && req.handler_done && cfg.sleep_after_handler)
        |=> state_r == PSW_SLEEP_INT)
        else $error("handler exit did not sleep");

    // Written on the raw inputs so a broken wake decode is caught
    int_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == PSW_SLEEP_INT && !wake.exc_entry_ok && !wake.debug_wake
         && !(priority_mask_bit && !fault_mask_bit && wake.irq_wake_masked))
        |=> state_r == PSW_SLEEP_INT)
        else $error("interrupt sleep woke without cause");

    ext_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == PSW_SLEEP_EVT && !wake.exc_entry_ok && !wake.debug_wake
         && $rose(ext_sync_r[1])) |=> (state_r == PSW_RUN && wake_pulse))
        else $error("external event did not wake");

    light_clk_a: assert property (@(posedge clk) disable iff (!rst_b)
        (sleeping && !deep_r) |-> (!pwr.cpu_clk_en && pwr.sys_clk_en && pwr.pll_on
         && pwr.flash_on))
        else $error("light sleep gated wrong clocks");

    deep_pwr_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == PSW_RUN && go_sleep_int && cfg.deep_sleep_select)
        |=> (!pwr.sys_clk_en && !pwr.pll_on && !pwr.flash_on))
        else $error("deep sleep left power on");

    defer_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == PSW_SLEEP_INT && priority_mask_bit && !fault_mask_bit
         && wake.irq_wake_masked && !wake.exc_entry_ok) |=> (!sleeping && defer_handler))
        else $error("masked interrupt wake did not defer handler");

    exc_evt_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == PSW_SLEEP_EVT && wake.exc_entry_ok) |=> (!sleeping && wake_pulse))
        else $error("exception did not wake event sleep");

    sev_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == PSW_SLEEP_EVT && $rose(sev_sync_r[1])) |=> !sleeping)
        else $error("send event did not wake event sleep");

    pend_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == PSW_SLEEP_EVT && cfg.wake_on_pending && wake.new_pending)
        |=> (!sleeping && wake_pulse))
        else $error("new pending interrupt did not wake");

    evt_latch_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r != PSW_SLEEP_EVT && $rose(ext_sync_r[1])) |=> event_flag)
        else $error("external event not latched while awake");

endmodule

`default_nettype wire

// ===== sim/psw_evt_src.sv
/*
 * Far-side model: a peripheral event line and another processor's send-event.
 * Assumes the bench raises a fire input; outputs are asynchronous to clk.
 */
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module psw_evt_src (
    input  wire logic fire_ext,   // Request a peripheral event
    input  wire logic fire_sev,   // Request a send-event
    output var  logic ext_event,  // Peripheral event line
    output var  logic send_event  // Other processor send-event line
);
    initial ext_event = 1'b0;
    initial send_event = 1'b0;

    // peripheral event pulse
    // 7 ns offset keeps the edge off the clock; 60 ns outlasts the synchroniser
    always @(posedge fire_ext) begin
        #7 ext_event = 1'b1;
        #60 ext_event = 1'b0;
    end

    always @(posedge fire_sev) begin
        #13 send_event = 1'b1;
        #60 send_event = 1'b0;
    end
endmodule

`default_nettype wire

// ===== sim/psw_ctrl_tb.sv
/*
 * Self-checking bench for the sleep and wakeup controller.
 * Assumes psw_pkg is compiled first; inputs change at the falling edge.
 */
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module psw_ctrl_tb;
    import psw_pkg::*;
    logic      clk, rst_b, pm, fm, exc, irqm, newp, dbg, fire_ext, fire_sev;
    psw_req_t  req;
    psw_cfg_t  cfg;
    psw_pwr_t  pwr;
    psw_wake_t wk;
    wire logic ext, send_event_instr;
    logic      sleeping, wake_pulse, defer_handler, event_flag;
    int        err_count = 0;
    int        total_checks = 0;

    assign wk = {exc, irqm, newp, ext, send_event_instr, dbg};

    psw_ctrl psw_ctrl_i (.clk(clk), .rst_b(rst_b), .req(req), .cfg(cfg),
        .priority_mask_bit(pm), .fault_mask_bit(fm), .wake(wk), .pwr(pwr),
        .sleeping(sleeping), .wake_pulse(wake_pulse),
        .defer_handler(defer_handler), .event_flag(event_flag));
    psw_evt_src psw_evt_src_i (.fire_ext(fire_ext), .fire_sev(fire_sev),
        .ext_event(ext), .send_event(send_event_instr));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input string name, input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One-cycle request; returns where the entry edge has landed
    task automatic do_req(input logic [2:0] r);
        req = r;
        cyc(1);
        req = 3'h0;
    endtask

    // Async sources need several cycles, so wait bounded, then expect the pulse
    task automatic wait_wake();
        for (int i = 0; i < 8 && sleeping !== 1'b0; i++) cyc(1);
        check("wake_pulse", wake_pulse, 1'b1);
    endtask

    task automatic final_report();
        if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog: the sequence needs well under 300 cycles
    initial begin
        #100000;
        err_count++;
        final_report();
    end

    // Main sequence
    initial begin
        {rst_b, pm, fm, exc, irqm, newp, dbg, fire_ext, fire_sev} = 9'h0;
        req = 3'h0;
        cfg = 3'h0;
        cyc(5);
        rst_b = 1'b1;
        check("event_flag", event_flag, 1'b0);
        check("pwr", pwr, 4'hf);
        do_req(3'h4);
        check("sleeping", sleeping, 1'b1);
        check("pwr", pwr, 4'h7);
        newp = 1'b1;
        cyc(1);
        newp = 1'b0;
        cyc(3);
        check("sleeping", sleeping, 1'b1);
        exc = 1'b1;
        cyc(1);
        exc = 1'b0;
        check("sleeping", sleeping, 1'b0);
        check("wake_pulse", wake_pulse, 1'b1);
        check("pwr", pwr, 4'hf);
        cfg = 3'h4;
        do_req(3'h4);
        cfg = 3'h0;
        cyc(1);
        check("pwr", pwr, 4'h0);
        dbg = 1'b1;
        cyc(1);
        dbg = 1'b0;
        check("sleeping", sleeping, 1'b0);
        check("pwr", pwr, 4'hf);
        pm = 1'b1;
        do_req(3'h4);
        irqm = 1'b1;
        cyc(1);
        irqm = 1'b0;
        check("sleeping", sleeping, 1'b0);
        cyc(1);
        check("defer_handler", defer_handler, 1'b1);
        pm = 1'b0;
        cyc(2);
        check("defer_handler", defer_handler, 1'b0);
        cfg = 3'h2;
        do_req(3'h1);
        check("sleeping", sleeping, 1'b1);
        dbg = 1'b1;
        cyc(1);
        dbg = 1'b0;
        cfg = 3'h0;
        do_req(3'h1);
        check("sleeping", sleeping, 1'b0);
        do_req(3'h2);
        check("sleeping", sleeping, 1'b1);
        fire_ext = 1'b1;
        wait_wake();
        fire_ext = 1'b0;
        do_req(3'h2);
        fire_sev = 1'b1;
        wait_wake();
        fire_sev = 1'b0;
        fire_ext = 1'b1;
        cyc(6);
        fire_ext = 1'b0;
        check("event_flag", event_flag, 1'b1);
        do_req(3'h2);
        check("sleeping", sleeping, 1'b0);
        check("event_flag", event_flag, 1'b0);
        // Pending interrupt without wake-on-pending must not end event sleep
        do_req(3'h2);
        newp = 1'b1;
        cyc(1);
        newp = 1'b0;
        check("sleeping", sleeping, 1'b1);
        exc = 1'b1;
        cyc(1);
        exc = 1'b0;
        check("sleeping", sleeping, 1'b0);
        check("wake_pulse", wake_pulse, 1'b1);
        // Fault mask set: masked interrupt must not wake
        pm = 1'b1;
        fm = 1'b1;
        do_req(3'h4);
        irqm = 1'b1;
        cyc(2);
        irqm = 1'b0;
        check("sleeping", sleeping, 1'b1);
        check("defer_handler", defer_handler, 1'b0);
        exc = 1'b1;
        cyc(1);
        {pm, fm, exc} = 3'h0;
        check("sleeping", sleeping, 1'b0);
        cfg = 3'h1;
        do_req(3'h2);
        newp = 1'b1;
        cyc(1);
        newp = 1'b0;
        wait_wake();
        // Mid-run reset while asleep with the event flag set
        cfg = 3'h0;
        fire_ext = 1'b1;
        cyc(6);
        fire_ext = 1'b0;
        check("event_flag", event_flag, 1'b1);
        do_req(3'h4);
        rst_b = 1'b0;
        cyc(1);
        check("event_flag", event_flag, 1'b0);
        check("sleeping", sleeping, 1'b0);
        check("pwr", pwr, 4'hf);
        rst_b = 1'b1;
        cyc(1);
        do_req(3'h2);
        check("sleeping", sleeping, 1'b1);
        final_report();
    end
endmodule

`default_nettype wire
